// [src/abu_defines.vh]
`ifndef ABU_DEFINES_VH
`define ABU_DEFINES_VH
// Break register byte offsets, three consecutive bytes from fe0c to fe0e
`define ABU_OFF_ADDR_HIGH 16'hfe0c
`define ABU_OFF_ADDR_LOW 16'hfe0d
`define ABU_OFF_STAT_CTRL 16'hfe0e
// Indexed registers: byte address is four times the index
`define ABU_ADDR_HIGH 18'h3f830
`define ABU_ADDR_LOW 18'h3f834
`define ABU_ADDR_STAT_CTRL 18'h3f838
`define ABU_ADDR_FLAG_CTRL 18'h3f83c
`define ABU_ADDR_SW_STAT 18'h3f840
`define ABU_ADDR_IRQ_STAT 18'h3f844
`define ABU_ADDR_IRQ_EN 18'h3f848
`define ABU_ADDR_IRQ_CLR 18'h3f84c
// Field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_CLR_EN 7
`define ABU_BIT_SWB 1
// Interrupt status bits
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_WAKE 2
`define ABU_NIRQ 3
// Vectors
`define ABU_VEC_NORMAL 16'hfffc
`define ABU_VEC_MONITOR 16'hfefc
`define ABU_RESET_BYTE 8'h00
`endif

// [src/abu_sync2.v]
`default_nettype none
module abu_sync2 (
   input wire ref_clk,
   input wire rst_n,
   input wire d,
   output reg q
);
   reg meta_r;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // abu_sync2
`default_nettype wire

// [src/abu_sticky.v]
`default_nettype none
// Sticky event bits: set wins over clear
module abu_sticky (
   input wire ref_clk,
   input wire rst_n,
   input wire [2:0] set,
   input wire [2:0] clr,
   output reg [2:0] q
);
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1)
      begin : g_bit
         always @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               q[i] <= 1'b0;
            else if (set[i])
               q[i] <= 1'b1;
            else if (clr[i])
               q[i] <= 1'b0;
         end
      end
   endgenerate
endmodule // abu_sticky
`default_nettype wire

// [src/abu_break_unit.v]
// Design decision made here: register access over APB.
`include "abu_defines.vh"
`default_nettype none
// Functional notes
// - Enabled address match raises breakpoint request
// - Request selects normal or monitor vector
// - Writing active bit one forces a break
// - Break starts at instruction boundary
// - Return-from-interrupt ends the break state
// - Enable bit 7 gates address breaks
// - Match sets active bit; software clears
// - Address high and low bytes, reset zero
// - Status register bits 5..0 read zero
// - Timer counter frozen during break
// - Watchdog off in break with test voltage
// - Stop/wait flag clear during break allowed only with clear-enable; active bit clear is not gated
// - Stop/wait flag cleared by writing zero
// - Break in stop wakes, sets stop/wait flag
// - Protected clears ignored in break without clear-enable
module abu_break_unit (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] cpu_addr,
   input wire cpu_addr_valid,
   input wire instr_last_cycle,
   input wire brk_accept,
   input wire rti_exec,
   input wire monitor_mode,
   input wire stop_mode,
   input wire wait_mode,
   input wire test_voltage_pin,
   output reg breakpoint_request,
   output reg [15:0] break_vector,
   output reg break_state,
   output reg timer_freeze,
   output reg watchdog_disable,
   output reg stop_wake,
   output reg status_clear_allow,
   output reg irq
);
   ////////////////////////////////////////////////////////////////////
   reg [7:0] break_address_high_r;
   reg [7:0] break_address_low_r;
   reg break_enable_bit_r;
   reg break_active_bit_r;
   reg break_clear_enable_r;
   reg stop_wait_break_flag_r;
   reg pending_r;
   reg [2:0] irq_en_r;
   wire [2:0] irq_stat;
   wire tv_sync;
   wire wr;
   wire rd;
   wire addr_hit;
   wire soft_break;
   wire match_event;
   wire accept_now;
   wire wake_event;
   reg [2:0] irq_clr;
   reg mapped;
   reg [31:0] rdata_nxt;

   abu_sync2 u_tv_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .d(test_voltage_pin),
      .q(tv_sync)
   );

   assign wr = psel & penable & pwrite & pready;
   assign rd = psel & penable & ~pwrite & pready;
   // Only program-counter addresses qualify
   assign addr_hit = cpu_addr_valid & break_enable_bit_r &
      (cpu_addr == {break_address_high_r, break_address_low_r});
   assign soft_break = wr & (paddr == `ABU_ADDR_STAT_CTRL) &
      pwdata[`ABU_BIT_ACTIVE] & ~break_active_bit_r;
   assign match_event = addr_hit & ~break_state;
   // Boundary accept; a match on the last cycle goes straight through
   assign accept_now = (pending_r | match_event | soft_break) &
      (brk_accept | instr_last_cycle) & ~break_state;
   assign wake_event = accept_now & stop_mode;

   ////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states after setup
   always @*
   begin
      mapped = 1'b1;
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         `ABU_ADDR_HIGH: rdata_nxt = {24'h000000, break_address_high_r};
         `ABU_ADDR_LOW: rdata_nxt = {24'h000000, break_address_low_r};
         `ABU_ADDR_STAT_CTRL:
            rdata_nxt = {24'h000000, break_enable_bit_r, break_active_bit_r,
               6'h00};
         `ABU_ADDR_FLAG_CTRL: rdata_nxt = {24'h000000, break_clear_enable_r, 7'h00};
         `ABU_ADDR_SW_STAT:
            rdata_nxt = {30'h00000000, stop_wait_break_flag_r, 1'b0};
         `ABU_ADDR_IRQ_STAT: rdata_nxt = {29'h00000000, irq_stat};
         `ABU_ADDR_IRQ_EN: rdata_nxt = {29'h00000000, irq_en_r};
         `ABU_ADDR_IRQ_CLR: rdata_nxt = 32'h0000_0000;
         default: mapped = 1'b0;
      endcase
   end

   always @*
   begin
      irq_clr = 3'h0;
      if (wr && paddr == `ABU_ADDR_IRQ_CLR)
         irq_clr = pwdata[2:0];
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite)
            prdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         break_address_high_r <= `ABU_RESET_BYTE;
         break_address_low_r <= `ABU_RESET_BYTE;
         break_enable_bit_r <= 1'b0;
         break_clear_enable_r <= 1'b0;
         irq_en_r <= 3'h0;
      end
      else if (wr)
      begin
         case (paddr)
            `ABU_ADDR_HIGH: break_address_high_r <= pwdata[7:0];
            `ABU_ADDR_LOW: break_address_low_r <= pwdata[7:0];
            `ABU_ADDR_STAT_CTRL: break_enable_bit_r <= pwdata[`ABU_BIT_ENABLE];
            `ABU_ADDR_FLAG_CTRL: break_clear_enable_r <= pwdata[`ABU_BIT_CLR_EN];
            `ABU_ADDR_IRQ_EN: irq_en_r <= pwdata[2:0];
            default: irq_en_r <= irq_en_r;
         endcase
      end
   end

   // Active bit: hardware set wins over a software clear
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         break_active_bit_r <= 1'b0;
      else if (match_event | soft_break)
         break_active_bit_r <= 1'b1;
      else if (wr && paddr == `ABU_ADDR_STAT_CTRL && !pwdata[`ABU_BIT_ACTIVE])
         break_active_bit_r <= 1'b0;
   end

   // Stop/wait flag; the clear is a protected status write
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         stop_wait_break_flag_r <= 1'b0;
      else if (wake_event)
         stop_wait_break_flag_r <= 1'b1;
      else if (wr && paddr == `ABU_ADDR_SW_STAT && !pwdata[`ABU_BIT_SWB] &&
         (!break_state || break_clear_enable_r))
         stop_wait_break_flag_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Pending latch keeps a match alive until the boundary
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending_r <= 1'b0;
         breakpoint_request <= 1'b0;
         break_state <= 1'b0;
         break_vector <= `ABU_VEC_NORMAL;
         timer_freeze <= 1'b0;
         watchdog_disable <= 1'b0;
         stop_wake <= 1'b0;
         status_clear_allow <= 1'b1;
         irq <= 1'b0;
      end
      else
      begin
         if (accept_now)
            pending_r <= 1'b0;
         else if (match_event | soft_break)
            pending_r <= 1'b1;
         breakpoint_request <= (pending_r | match_event | soft_break) &
            ~accept_now & ~break_state;
         if (accept_now)
            break_state <= 1'b1;
         else if (rti_exec)
            break_state <= 1'b0;
         break_vector <= monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
         timer_freeze <= accept_now | (break_state & ~rti_exec);
         watchdog_disable <= (accept_now | (break_state & ~rti_exec)) & tv_sync;
         stop_wake <= wake_event;
         // Wait mode keeps matching; no gating by wait_mode
         status_clear_allow <= ~(accept_now | (break_state & ~rti_exec)) |
            break_clear_enable_r;
         irq <= |(irq_stat & irq_en_r);
      end
   end

   abu_sticky u_irq (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set({wake_event, soft_break, match_event}),
      .clr(irq_clr),
      .q(irq_stat)
   );

   wire unused_ok = wait_mode;
endmodule // abu_break_unit
`default_nettype wire

// [test/abu_cpu_model.sv]
`default_nettype none
module abu_cpu_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic breakpoint_request,
   output logic [15:0] cpu_addr,
   output logic cpu_addr_valid,
   output logic instr_last_cycle,
   output logic brk_accept
);
   timeunit 1ns;
   timeprecision 1ps;
   // Four-cycle instructions, so a request may wait three cycles
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         cpu_addr <= 16'h0;
      else
         cpu_addr <= cpu_addr + 16'h1;
   assign cpu_addr_valid = rst_n;
   assign instr_last_cycle = &cpu_addr[1:0];
   // Taken at a boundary; the address keeps counting, no trap instruction is modelled
   assign brk_accept = breakpoint_request & instr_last_cycle;
endmodule // abu_cpu_model
`default_nettype wire

// [test/abu_monitor.sv]
`default_nettype none
module abu_monitor (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic brk_accept,
   input wire logic rti_exec,
   input wire logic monitor_mode,
   input wire logic breakpoint_request,
   input wire logic [15:0] break_vector,
   input wire logic break_state,
   input wire logic timer_freeze,
   input wire logic watchdog_disable,
   input wire logic status_clear_allow,
   input wire logic stop_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_req_held: assert property (
      breakpoint_request && !brk_accept |=> breakpoint_request) else $error("request lost");
   chk_take_break: assert property (
      breakpoint_request && brk_accept |=> break_state && !breakpoint_request)
      else $error("accept gave no break");
   chk_rti_exit: assert property (
      break_state && rti_exec |=> !break_state) else $error("break kept after return");
   chk_timer_stop: assert property (
      $stable(break_state) |-> timer_freeze == break_state) else $error("timer freeze wrong");
   chk_wdog_gate: assert property (
      watchdog_disable |-> break_state || $past(break_state)) else $error("watchdog off");
   chk_vector_sel: assert property (
      break_state && $stable(monitor_mode) |-> break_vector == (monitor_mode ? 16'hfefc :
      16'hfffc)) else $error("vector wrong");
   chk_apb_pulse: assert property (
      psel && !penable |=> pready ##1 !pready) else $error("ready timing");
   chk_clear_allow: assert property (
      !break_state && !$past(break_state) |-> status_clear_allow) else $error("clear blocked");
   chk_wake_entry: assert property (
      stop_wake |-> $rose(break_state)) else $error("wake without break entry");
   cover property ($rose(break_state));
   cover property (breakpoint_request && brk_accept);
   cover property (watchdog_disable);
   cover property (stop_wake);
endmodule // abu_monitor
bind abu_break_unit abu_monitor mon (.ref_clk, .rst_n, .psel, .penable, .pready, .brk_accept,
   .rti_exec, .monitor_mode, .breakpoint_request, .break_vector, .break_state,
   .timer_freeze, .watchdog_disable, .status_clear_allow, .stop_wake);
`default_nettype wire

// [test/tb.sv]
`include "abu_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [17:0] a; logic [31:0] d; logic [8:0] e;} abu_row_t;
   logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic rti_exec = 1'h0, monitor_mode = 1'h0, stop_mode = 1'h0, tv = 1'h0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] cpu_addr, break_vector, t;
   logic pready, pslverr, er, cpu_addr_valid, instr_last_cycle, brk_accept;
   logic breakpoint_request, break_state, timer_freeze, watchdog_disable, status_clear_allow, irq;
   int errors = 0, compares = 0, n;
   // Read value in low byte, slave error as the top bit
   abu_row_t rows [6] = '{'{1'h1, `ABU_ADDR_HIGH, 32'h12345678, 9'h078},
      '{1'h1, `ABU_ADDR_LOW, 32'hab, 9'h0ab}, '{1'h1, `ABU_ADDR_STAT_CTRL, 32'h3f, 9'h000},
      '{1'h1, `ABU_ADDR_FLAG_CTRL, 32'h80, 9'h080}, '{1'h1, `ABU_ADDR_IRQ_EN, 32'h7, 9'h007},
      '{1'h1, 18'h00100, 32'hff, 9'h100}};
   abu_break_unit dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cpu_addr, .cpu_addr_valid, .instr_last_cycle, .brk_accept,
      .rti_exec, .monitor_mode, .stop_mode, .wait_mode(1'h0), .test_voltage_pin(tv),
      .breakpoint_request, .break_vector, .break_state, .timer_freeze, .watchdog_disable,
      .stop_wake(), .status_clear_allow, .irq);
   abu_cpu_model cpu (.ref_clk, .rst_n, .breakpoint_request, .cpu_addr, .cpu_addr_valid,
      .instr_last_cycle, .brk_accept);
   initial forever #2 ref_clk = ~ref_clk;
   task finish_test;
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      compares++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task tmo;
      if (n >= 64)
      begin
         errors++;
         finish_test;
      end
   endtask
   task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      for (n = 0; n < 64 && pready !== 1'h1; n++)
         @(posedge ref_clk);
      tmo;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Two idle edges let registered flags settle
      repeat (2) @(posedge ref_clk);
   endtask
   task wb(input logic v);
      for (n = 0; n < 64 && break_state !== v; n++)
         @(posedge ref_clk);
      tmo;
   endtask
   task setbrk(input logic [1:0] lo);
      t = {cpu_addr[15:2] + 14'h10, lo};
      apb(1'h1, `ABU_ADDR_HIGH, {24'h0, t[15:8]});
      apb(1'h1, `ABU_ADDR_LOW, {24'h0, t[7:0]});
      apb(1'h1, `ABU_ADDR_STAT_CTRL, 32'h80);
      wb(1'h1);
   endtask
   task leave;
      apb(1'h1, `ABU_ADDR_STAT_CTRL, 32'h0);
      rti_exec <= 1'h1;
      @(posedge ref_clk);
      rti_exec <= 1'h0;
      wb(1'h0);
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         apb(1'h0, rows[i].a, 32'h0);
         chk({er, rd}, {rows[i].e[8], 24'h0, rows[i].e[7:0]});
      end
      setbrk(2'h1);
      chk(cpu_addr, t + 16'h3);
      chk(timer_freeze, 1'h1);
      chk(break_vector, `ABU_VEC_NORMAL);
      apb(1'h0, `ABU_ADDR_STAT_CTRL, 32'h0);
      chk(rd, 32'hc0);
      leave;
      monitor_mode <= 1'h1;
      tv <= 1'h1;
      setbrk(2'h3);
      chk(cpu_addr, t + 16'h1);
      chk(break_vector, `ABU_VEC_MONITOR);
      apb(1'h1, `ABU_ADDR_IRQ_CLR, 32'h7);
      chk({watchdog_disable, irq}, 2'h2);
      leave;
      monitor_mode <= 1'h0;
      apb(1'h1, `ABU_ADDR_FLAG_CTRL, 32'h0);
      stop_mode <= 1'h1;
      apb(1'h1, `ABU_ADDR_STAT_CTRL, 32'h40);
      wb(1'h1);
      stop_mode <= 1'h0;
      apb(1'h1, `ABU_ADDR_SW_STAT, 32'h0);
      chk({status_clear_allow, irq}, 2'h1);
      apb(1'h0, `ABU_ADDR_SW_STAT, 32'h0);
      chk(rd, 32'h2);
      apb(1'h0, `ABU_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h6);
      apb(1'h1, `ABU_ADDR_IRQ_EN, 32'h0);
      chk(irq, 1'h0);
      apb(1'h1, `ABU_ADDR_FLAG_CTRL, 32'h80);
      apb(1'h1, `ABU_ADDR_SW_STAT, 32'h0);
      apb(1'h0, `ABU_ADDR_SW_STAT, 32'h0);
      chk(rd, 32'h0);
      rst_n <= 1'h0;
      @(posedge ref_clk);
      chk(break_state, 1'h0);
      rst_n <= 1'h1;
      apb(1'h0, `ABU_ADDR_HIGH, 32'h0);
      chk(rd, 32'h0);
      finish_test;
   end
endmodule // tb
`default_nettype wire
